//--- rtl/mode_pkg.sv
// Constants shared by the operating mode select block.
// Assumes a 32-bit APB master on pclk and mode pins that are stable around reset release.
// Summary of operation
// - Reset mode comes from three mode pins.
// - Pins captured into mode bits at reset release.
// - Three-bit code decodes to eight modes.
// - Only limited mode changes while running.
// - Each mode sets map and bus configuration.
// - Normal modes protect control bits from writes.
// - Special single-chip starts with debug active.
// - Normal modes refuse debug until enabled.
// - Single-chip modes: ports A, B general purpose.
// - Wide mode: ports A, B carry 16-bit data.
// - Narrow mode: port A carries 8-bit data.
// - Narrow word: high byte, then low, address+1.
// - Expanded/peripheral unmap port A, B registers.
// - Port E registers unmapped per mode, emulation.
// - Port K registers unmapped per mode, emulation.
// - Reserved locations read as zero.
// - Mode bit writes: once normal, special skip first.
// - Peripheral mode only through reset; core idle.
package mode_pkg;

    // Register byte offsets.
    localparam logic [11:0] MODE_OFF   = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;

    // Mode register field positions.
    localparam int SMN_BIT    = 7;
    localparam int MB_BIT     = 6;
    localparam int MA_BIT     = 5;
    localparam int ESTR_BIT   = 4;
    localparam int IVIS_BIT   = 3;
    localparam int EBSWAI_BIT = 2;
    localparam int EMK_BIT    = 1;
    localparam int EME_BIT    = 0;

    // Values after reset: code, and option bits {estr, ivis, ebswai, emk, eme}.
    localparam logic [2:0] MODE_CODE_RST = 3'h0;
    localparam logic [4:0] OPT_RST_SPEC  = 5'h1B;
    localparam logic [4:0] OPT_RST_NORM  = 5'h10;

    // Mode codes {special_mode_not, mode_b, mode_a}.
    localparam logic [2:0] MODE_NSC  = 3'h4;
    localparam logic [2:0] MODE_NXN  = 3'h5;
    localparam logic [2:0] MODE_NRSV = 3'h6;
    localparam logic [2:0] MODE_NXW  = 3'h7;
    localparam logic [2:0] MODE_SSC  = 3'h0;
    localparam logic [2:0] MODE_SXN  = 3'h1;
    localparam logic [2:0] MODE_SPER = 3'h2;
    localparam logic [2:0] MODE_SXW  = 3'h3;

    // Low two code bits that select the peripheral pattern.
    localparam logic [1:0] AB_PERIPH = 2'h2;

    // External bus sequencer states.
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_HIGH = 3'b010,
        BUS_LOW  = 3'b100
    } bus_state_t;

endpackage

//--- rtl/operating_mode_select.sv
// Operating mode latch, mode register, map decode, debug gate and bus sequencer.
// Assumes an APB master on pclk and a bus requester on pclk that waits for ext_ready.
`timescale 1ns/1ns
module operating_mode_select
    import mode_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        background_pin,
    input  wire logic        mode_pin_b,
    input  wire logic        mode_pin_a,
    input  wire logic        bg_enable_cmd,
    input  wire logic        debug_op_req,
    output logic             debug_op_grant,
    output logic             debug_active,
    output logic             cpu_active,
    output logic             protect_active,
    output logic [2:0]       mode_code,
    output logic             port_a_bus,
    output logic             port_b_bus,
    output logic             port_b_data,
    output logic             port_ab_mapped,
    output logic             port_e_mapped,
    output logic             port_k_mapped,
    output logic             mode_reg_mapped,
    output logic             ext_clock_stretch,
    input  wire logic        ext_req,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    output logic             ext_ready,
    output logic             bus_cycle,
    output logic             bus_byte_high,
    output logic [15:0]      bus_addr,
    output logic [15:0]      bus_data
);

    logic [2:0]  pin_meta_reg;
    logic [2:0]  pin_sync_reg;
    logic        latched_reg;
    logic [2:0]  mode_code_reg;
    logic [2:0]  mode_code_next;
    logic [4:0]  opt_reg;
    logic [4:0]  opt_next;
    logic        once_reg;
    logic        first_reg;
    logic        debug_en_reg;
    bus_state_t  state_reg;
    logic [15:0] bus_addr_reg;
    logic [15:0] bus_data_reg;
    logic [7:0]  lo_byte_reg;
    wire         is_special;
    wire         is_periph;
    wire         is_single;
    wire         is_narrow;
    wire         is_wide;
    wire         is_expanded;
    wire         apb_wr;
    wire         wr_mode;
    wire         take_norm;
    wire         take_spec;
    wire         ab_legal;
    wire [31:0]  status_word;

    ////////////////////////////////////////////////////////////////////////////
    // Mode pin synchroniser. No reset, so pin levels flow through during reset
    // and are valid at the release edge.
    always_ff @(posedge pclk) begin
        pin_meta_reg <= {background_pin, mode_pin_b, mode_pin_a};
        pin_sync_reg <= pin_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode. Reserved 110 behaves as peripheral, like 010.
    assign is_special  = ~mode_code_reg[2];
    assign is_periph   = (mode_code_reg[1:0] == AB_PERIPH);
    assign is_single   = (mode_code_reg[1:0] == 2'h0);
    assign is_narrow   = (mode_code_reg[1:0] == 2'h1);
    assign is_wide     = (mode_code_reg[1:0] == 2'h3);
    assign is_expanded = is_narrow | is_wide;

    // Bus, map and protection configuration per mode.
    assign port_a_bus      = latched_reg & ~is_single;
    assign port_b_bus      = latched_reg & ~is_single;
    assign port_b_data     = latched_reg & (is_wide | is_periph);
    assign port_ab_mapped  = is_single;
    assign port_e_mapped   = ~is_periph & ~(is_expanded & opt_reg[EME_BIT]);
    assign port_k_mapped   = ~is_periph & ~(is_expanded & opt_reg[EMK_BIT]);
    assign mode_reg_mapped = ~is_periph;
    assign cpu_active      = latched_reg & ~is_periph;
    assign protect_active  = ~is_special;
    assign mode_code       = mode_code_reg;
    // Stretch is forced in expanded modes since demultiplexing needs it.
    assign ext_clock_stretch = opt_reg[ESTR_BIT] | is_expanded;

    ////////////////////////////////////////////////////////////////////////////
    // Debug gate. Peripheral mode keeps debug off to avoid bus fights.
    assign debug_active   = debug_en_reg & ~is_periph;
    assign debug_op_grant = debug_op_req & debug_active;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, never an error.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign apb_wr  = psel & penable & pwrite;
    assign wr_mode = apb_wr & (paddr == MODE_OFF) & latched_reg & ~is_periph;
    // Normal modes take one write; special modes skip the first.
    assign take_norm = ~is_special & ~once_reg;
    assign take_spec = is_special & first_reg;
    assign ab_legal  = (pwdata[MB_BIT:MA_BIT] != AB_PERIPH);
    assign status_word = {22'h0, latched_reg, debug_active, cpu_active, port_k_mapped,
                          port_e_mapped, port_ab_mapped, is_narrow, is_wide, is_periph,
                          is_special};

    // Read mux; reserved and unmapped addresses read zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == MODE_OFF && ~is_periph) begin
            prdata = {24'h0, mode_code_reg, ext_clock_stretch, opt_reg[3:0]};
        end else if (paddr == STATUS_OFF) begin
            prdata = status_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next mode code and options on a mode register write.
    always_comb begin
        mode_code_next = mode_code_reg;
        opt_next       = opt_reg;
        if (wr_mode) begin
            if (take_spec) begin
                mode_code_next[2] = pwdata[SMN_BIT];
            end
            if ((take_norm | take_spec) & ab_legal) begin
                mode_code_next[1:0] = pwdata[MB_BIT:MA_BIT];
            end
            if (take_norm | is_special) begin
                opt_next[ESTR_BIT] = pwdata[ESTR_BIT];
            end
            if (take_norm | take_spec) begin
                opt_next[IVIS_BIT] = pwdata[IVIS_BIT];
                opt_next[EMK_BIT]  = pwdata[EMK_BIT];
                opt_next[EME_BIT]  = pwdata[EME_BIT];
            end
            if (~is_special) begin
                opt_next[EBSWAI_BIT] = pwdata[EBSWAI_BIT];
            end
        end
    end

    // Mode state. The first edge after reset release captures the pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_reg   <= 1'b0;
            mode_code_reg <= MODE_CODE_RST;
            opt_reg       <= OPT_RST_NORM;
            once_reg      <= 1'b0;
            first_reg     <= 1'b0;
            debug_en_reg  <= 1'b0;
        end else if (!latched_reg) begin
            latched_reg   <= 1'b1;
            mode_code_reg <= pin_sync_reg;
            opt_reg       <= pin_sync_reg[2] ? OPT_RST_NORM : OPT_RST_SPEC;
            debug_en_reg  <= (pin_sync_reg == MODE_SSC);
        end else begin
            mode_code_reg <= mode_code_next;
            opt_reg       <= opt_next;
            once_reg      <= once_reg | (wr_mode & ~is_special);
            first_reg     <= first_reg | (wr_mode & is_special);
            debug_en_reg  <= debug_en_reg | bg_enable_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External bus sequencer. Narrow mode splits a word into two byte cycles.
    assign ext_ready     = (state_reg == BUS_IDLE) & is_expanded;
    assign bus_cycle     = ~state_reg[0];
    assign bus_byte_high = state_reg[1] & is_narrow;
    assign bus_addr      = bus_addr_reg;
    assign bus_data      = bus_data_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= BUS_IDLE;
            bus_addr_reg <= 16'h0000;
            bus_data_reg <= 16'h0000;
            lo_byte_reg  <= 8'h00;
        end else begin
            unique case (state_reg)
                BUS_IDLE: begin
                    if (ext_req & is_expanded) begin
                        state_reg    <= BUS_HIGH;
                        bus_addr_reg <= ext_addr;
                        lo_byte_reg  <= ext_wdata[7:0];
                        // Narrow carries the high byte first, wide the whole word.
                        bus_data_reg <= is_narrow ? {8'h00, ext_wdata[15:8]}
                                                  : ext_wdata;
                    end
                end
                BUS_HIGH: begin
                    if (is_narrow) begin
                        state_reg    <= BUS_LOW;
                        bus_addr_reg <= bus_addr_reg + 16'h0001;
                        bus_data_reg <= {8'h00, lo_byte_reg};
                    end else begin
                        state_reg <= BUS_IDLE;
                    end
                end
                BUS_LOW: begin
                    state_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence narrow_high_s;
        state_reg == BUS_HIGH && is_narrow;
    endsequence
    sequence narrow_low_s;
        state_reg == BUS_LOW && bus_addr_reg == $past(bus_addr_reg) + 16'h0001;
    endsequence

    AST_LATCH: assert property ($rose(latched_reg) |-> mode_code_reg == $past(pin_sync_reg))
        else $error("Mode code does not match pins at reset release.");
    AST_NARROW: assert property (narrow_high_s |=> narrow_low_s ##1 state_reg == BUS_IDLE)
        else $error("Narrow word did not take two cycles with address step.");
    AST_SINGLE: assert property (latched_reg && is_single |-> !port_a_bus && !port_b_bus)
        else $error("Single-chip mode drives the external bus.");
    AST_WIDE: assert property (latched_reg && is_wide |-> port_a_bus && port_b_data)
        else $error("Wide mode lacks data on both ports.");
    AST_SSC_DEBUG: assert property ($rose(latched_reg) && mode_code_reg == MODE_SSC |-> debug_active)
        else $error("Special single-chip mode left debug inactive.");
    AST_DEBUG_REFUSE: assert property (!debug_en_reg |-> !debug_op_grant)
        else $error("Debug operation granted before enable.");
    AST_CODE_HOLD: assert property (latched_reg && !wr_mode |=> $stable(mode_code_reg))
        else $error("Mode code changed without a mode write.");
    AST_PERIPH_HOLD: assert property (latched_reg |=> $stable(is_periph))
        else $error("Peripheral mode entered or left without reset.");
    AST_FIRST_SKIP: assert property (wr_mode && is_special && !first_reg |=> $stable(mode_code_reg))
        else $error("First special-mode write changed the mode code.");
    AST_PROTECT: assert property (wr_mode && !is_special && once_reg |=> $stable(mode_code_reg) && $stable(opt_reg[IVIS_BIT]))
        else $error("Protected bits changed after the single write.");
    AST_AB_MAP: assert property (!is_single |-> !port_ab_mapped)
        else $error("Port A and B registers mapped outside single-chip.");
    AST_E_MAP: assert property (is_periph || (is_expanded && opt_reg[EME_BIT]) |-> !port_e_mapped)
        else $error("Port E registers left mapped.");
    AST_K_MAP: assert property (is_periph || (is_expanded && opt_reg[EMK_BIT]) |-> !port_k_mapped)
        else $error("Port K registers left mapped.");

endmodule

//--- bench/ext_bus_model.sv
// External bus partner: a listener that records each external bus cycle.
// Assumes bus outputs are registered on pclk and stay steady while bus_cycle is high.
`timescale 1ns/1ns
module ext_bus_model (
    input  wire logic        pclk,
    input  wire logic        bus_cycle,
    input  wire logic        bus_byte_high,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_data,
    output logic [7:0]       cyc_count,
    output logic [32:0]      prev_cyc,
    output logic [32:0]      last_cyc
);
    ////////////////////////////////////////////////////////////////////////////////
    // Keep the two most recent cycles as {byte_high, addr, data}.
    // Two entries are enough, since a narrow word is the longest burst.
    initial cyc_count = 8'h00;
    always @(posedge pclk) begin
        if (bus_cycle === 1'b1) begin
            cyc_count <= cyc_count + 8'h01;
            prev_cyc  <= last_cyc;
            last_cyc  <= {bus_byte_high, bus_addr, bus_data};
        end
    end
endmodule

//--- bench/test_operating_mode_select.sv
// Self-checking bench for the operating mode select block.
// Assumes the mode package and the external bus partner are compiled first.
`timescale 1ns/1ns
module test_operating_mode_select
    import mode_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        background_pin = 1'b1, mode_pin_b = 1'b0, mode_pin_a = 1'b0;
    logic        bg_enable_cmd = 1'b0, debug_op_req = 1'b0, ext_req = 1'b0;
    logic [15:0] ext_addr = 16'h0000, ext_wdata = 16'h0000, bus_addr, bus_data;
    logic        pready, pslverr, debug_op_grant, debug_active, cpu_active, protect_active;
    logic        port_a_bus, port_b_bus, port_b_data, port_ab_mapped, port_e_mapped;
    logic        port_k_mapped, mode_reg_mapped, ext_clock_stretch, ext_ready;
    logic        bus_cycle, bus_byte_high;
    logic [2:0]  mode_code;
    logic [7:0]  cyc_count;
    logic [32:0] prev_cyc, last_cyc;
    int          err_total = 0, n_checks = 0;

    // Design and bus partner, joined by matching names.
    operating_mode_select i_operating_mode_select (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
        .pslverr, .background_pin, .mode_pin_b, .mode_pin_a, .bg_enable_cmd,
        .debug_op_req, .debug_op_grant, .debug_active, .cpu_active, .protect_active,
        .mode_code, .port_a_bus, .port_b_bus, .port_b_data, .port_ab_mapped,
        .port_e_mapped, .port_k_mapped, .mode_reg_mapped, .ext_clock_stretch, .ext_req,
        .ext_addr, .ext_wdata, .ext_ready, .bus_cycle, .bus_byte_high, .bus_addr, .bus_data
    );
    ext_bus_model i_ext_bus_model (
        .pclk, .bus_cycle, .bus_byte_high, .bus_addr, .bus_data, .cyc_count, .prev_cyc,
        .last_cyc
    );

    // Clock of 4 ns period.
    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Case equality, so an unknown never counts as a match.
    task chk(input logic [32:0] got, input logic [32:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        chk(pslverr, 1'b0, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        // Step off the edge so later compares see the settled register state.
        #1;
    endtask

    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd_reg(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Pins are steady for all six reset cycles, well past the synchroniser depth.
    task do_reset(input logic [2:0] code);
        @(posedge pclk);
        presetn <= 1'b0;
        {background_pin, mode_pin_b, mode_pin_a} <= code;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // One-cycle background enable pulse from the debug host.
    task bg_pulse;
        @(posedge pclk);
        bg_enable_cmd <= 1'b1;
        @(posedge pclk);
        bg_enable_cmd <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    // Bus request held until taken, then time for a whole narrow word to finish.
    task bus_req(input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        ext_req <= 1'b1;
        ext_addr <= a;
        ext_wdata <= d;
        do @(posedge pclk); while (ext_ready !== 1'b1 && ++n < 50);
        if (n >= 50) err_total++;
        ext_req <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
    endtask

    // Expected levels {a_bus, b_bus, b_data, ab_map, e_map, k_map, mode_map, cpu,
    // protect, debug, ext_ready, stretch} right after reset in a given mode.
    function automatic logic [11:0] exp_out(input logic [2:0] c);
        logic sc, per, xp;
        sc = (c[1:0] == 2'h0);
        per = (c[1:0] == 2'h2);
        xp = !sc && !per;
        exp_out = {!sc, !sc, c[1], sc, sc | (xp & c[2]), sc | (xp & c[2]), !per, !per,
                   c[2], c == 3'h0, xp, 1'b1};
    endfunction

    task give_verdict;
        $display("checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Every mode from reset, then mode register writes, bus cycles and a hole.
    initial begin
        logic [11:0] o;
        logic [7:0]  n0;
        @(posedge pclk);
        debug_op_req <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0]);
            o = exp_out(i[2:0]);
            chk(mode_code, i[2:0], "mode code");
            chk({port_a_bus, port_b_bus, port_b_data, port_ab_mapped, port_e_mapped,
                 port_k_mapped, mode_reg_mapped, cpu_active, protect_active, debug_active,
                 ext_ready, ext_clock_stretch}, o, "mode outputs");
            chk(debug_op_grant, i == 0, "grant before enable");
            rd_reg(STATUS_OFF);
            chk(rd, {1'b1, o[2], o[4], o[6], o[7], o[8], i[1:0] == 2'h1, i[1:0] == 2'h3,
                     i[1:0] == 2'h2, !i[2]}, "status");
            rd_reg(MODE_OFF);
            chk(rd, (i[1:0] == 2'h2) ? 8'h00 : {i[2:0], i[2] ? 5'h10 : 5'h1B}, "mode reg");
            wr_reg(MODE_OFF, 32'h0000_007B);
            if (i[1:0] == 2'h2) chk(mode_code, i[2:0], "peripheral code held");
            bg_pulse;
            chk(debug_op_grant, o[5], "grant after enable");
        end
        do_reset(3'h4);
        wr_reg(MODE_OFF, 32'h0000_00F7);
        rd_reg(MODE_OFF);
        chk(rd, 8'hF7, "normal first write");
        chk({port_e_mapped, port_k_mapped}, 2'h0, "emulated maps");
        n0 = cyc_count;
        bus_req(16'h2468, 16'hBEEF);
        chk(cyc_count - n0, 8'h01, "wide count");
        chk(last_cyc, {1'b0, 16'h2468, 16'hBEEF}, "wide cycle");
        wr_reg(MODE_OFF, 32'h0000_00A4);
        rd_reg(MODE_OFF);
        chk(rd, 8'hF7, "normal later write");
        do_reset(3'h5);
        n0 = cyc_count;
        bus_req(16'h12FF, 16'hABCD);
        chk(cyc_count - n0, 8'h02, "narrow count");
        chk(prev_cyc, {1'b1, 16'h12FF, 16'h00AB}, "narrow high");
        chk(last_cyc, {1'b0, 16'h1300, 16'h00CD}, "narrow low");
        do_reset(3'h0);
        wr_reg(MODE_OFF, 32'h0000_007B);
        rd_reg(MODE_OFF);
        chk(rd, 8'h1B, "special first write");
        wr_reg(MODE_OFF, 32'h0000_007B);
        rd_reg(MODE_OFF);
        chk(rd, 8'h7B, "special second write");
        chk(mode_code, 3'h3, "special code");
        wr_reg(MODE_OFF, 32'h0000_005B);
        rd_reg(MODE_OFF);
        chk(rd, 8'h7B, "peripheral refused");
        rd_reg(12'h008);
        chk(rd, 32'h0000_0000, "unmapped read");
        give_verdict;
    end

    // Watchdog, well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        give_verdict;
    end
endmodule
